// >>> rtl/pacer_pkg.sv
// Package with the constants and carrier types of the pacer quadrature repeater.
package pacer_pkg;
    localparam int             SCALE_W     = 13;
    localparam logic [12:0]    SCALE_DEN   = 13'h1000;
    localparam logic [12:0]    SCALE_RST   = 13'h1000;
    localparam int             POS_W       = 32;
    localparam logic [31:0]    POS_RST     = 32'h00000000;
    localparam logic [1:0]     QUAD_RST    = 2'h0;

    // One quadrature pair, phase A and phase B.
    typedef struct packed {
        logic a;
        logic b;
    } quad_t;

    // Output source selection.
    typedef enum logic [1:0] {
        SRC_AUX   = 2'h1,
        SRC_MOTOR = 2'h2
    } src_t;
endpackage : pacer_pkg

// >>> rtl/pacer_quadrature_repeater.sv
// Auxiliary quadrature decoder, gearing master and selectable quadrature repeater.
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1 - Decode auxiliary A/B pair into a position count; A leading B counts down (CCW).
// R2 - Decoded auxiliary position and step pulses feed the gearing master outputs.
// R3 - Source select picks auxiliary pair or motor feedback for the output pair.
// R4 - Auxiliary source: input phases are redriven unchanged onto the output pair.
// R5 - Motor source: phases pass directly, or a scaled-down version is emitted.
// R6 - Scaled output counts equal motor counts times scale factor over 4096.
// R7 - Scale factors above 4096 are clamped, so resolution never rises.
// R8 - Scaling applies only to motor source; auxiliary repeat is never scaled.
// R9 - Accumulator tracks direction, so returning motor gives same output position.
// R10 - Configuring party supplies integer-ratio factors; no option in the logic enforces it.
// R11 - Add factor per motor count modulo 4096; step output state on each overflow.
module pacer_quadrature_repeater
(
    input  wire logic                            clk,          // 10 MHz clock.
    input  wire logic                            arst_n,       // Asynchronous reset, active low.
    input  wire pacer_pkg::quad_t                aux_in,       // Auxiliary pair aux_phase_a_in/aux_phase_b_in.
    input  wire logic                            aux_index_in, // Auxiliary once-per-rev index.
    input  wire pacer_pkg::quad_t                motor_in,     // Motor feedback quadrature pair.
    input  wire logic                            src_motor,    // High selects motor feedback as source.
    input  wire logic                            scale_en,     // High enables scaling of motor source.
    input  wire logic [pacer_pkg::SCALE_W-1:0]   scale_factor, // Numerator over 4096.
    output logic      [pacer_pkg::POS_W-1:0]     aux_pos,      // Decoded auxiliary position.
    output logic                                 aux_step,     // One-cycle pulse per auxiliary count.
    output logic                                 aux_dir_ccw,  // Direction of last auxiliary count.
    output logic                                 aux_index,    // Synchronised index level.
    output pacer_pkg::quad_t                     quad_out      // Quadrature output pair.
);

    logic                          rst_a_ff, rst_n_ff;
    pacer_pkg::quad_t              aux_s1_ff, aux_s2_ff, aux_prev_ff;
    pacer_pkg::quad_t              mot_s1_ff, mot_s2_ff, mot_prev_ff;
    logic                          idx_s1_ff;
    logic [1:0]                    scl_state_ff;
    logic [11:0]                   acc_ff;
    pacer_pkg::src_t               src_ff;
    logic                          aux_mv, aux_up, mot_mv, mot_up;
    logic [12:0]                   eff_scale;
    logic [12:0]                   acc_sum;
    logic                          acc_ovf;
    logic [12:0]                   acc_dif;
    logic                          acc_unf;
    logic [2:0]                    prime_ff;

    // Reset release through two flip-flops. The assertion of arst_n is seen at
    // once, while its release is retimed so every register below leaves reset on
    // the same clock edge, whatever the phase of the external reset.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_a_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end
        else
        begin
            rst_a_ff <= 1'b1;
            rst_n_ff <= rst_a_ff;
        end
    end

    // Start-up guard. After reset the history stages hold 00 while the pins may sit
    // anywhere in the Gray cycle, so the first compare could invent one count on
    // each pair. Decode waits until three edges have loaded real pin samples into
    // both the second synchroniser stage and the previous-value stage.
    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            prime_ff <= 3'h0;
        else
            prime_ff <= {prime_ff[1:0], 1'b1};
    end

    // Pin synchronisers; only the second stage is read by logic.
    // The pins are asynchronous, so the first stage may go metastable; it gets a
    // whole clock period to settle before the second stage passes it on.
    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            aux_s1_ff   <= pacer_pkg::QUAD_RST;
            aux_s2_ff   <= pacer_pkg::QUAD_RST;
            aux_prev_ff <= pacer_pkg::QUAD_RST;
            mot_s1_ff   <= pacer_pkg::QUAD_RST;
            mot_s2_ff   <= pacer_pkg::QUAD_RST;
            mot_prev_ff <= pacer_pkg::QUAD_RST;
            idx_s1_ff   <= 1'b0;
            aux_index   <= 1'b0;
        end
        else
        begin
            aux_s1_ff   <= aux_in;
            aux_s2_ff   <= aux_s1_ff;
            aux_prev_ff <= aux_s2_ff;
            mot_s1_ff   <= motor_in;
            mot_s2_ff   <= mot_s1_ff;
            mot_prev_ff <= mot_s2_ff;
            idx_s1_ff   <= aux_index_in;
            aux_index   <= idx_s1_ff;
        end
    end

    // Quadrature step decode, X4. Up means B leading A (CW); A leading B counts down.
    // Over one legal step exactly one phase flips, so the direction is the old A
    // against the new B: equal for a down step, different for an up step.
    // A double transition is an illegal jump and is ignored rather than guessed.
    // Pin edges closer than one clock apart may merge into one such illegal jump.
    // Nothing is decoded until prime_ff shows that both history stages hold pin samples.
    always_comb
    begin
        aux_mv = prime_ff[2] & ((aux_s2_ff.a ^ aux_prev_ff.a) ^ (aux_s2_ff.b ^ aux_prev_ff.b)); // R1
        aux_up = aux_prev_ff.a ^ aux_s2_ff.b;                                    // R1
        mot_mv = prime_ff[2] & ((mot_s2_ff.a ^ mot_prev_ff.a) ^ (mot_s2_ff.b ^ mot_prev_ff.b));
        mot_up = mot_prev_ff.a ^ mot_s2_ff.b;
    end

    // Auxiliary position count and step pulses used as the gearing master.
    // The follower logic may take either the running count or the step and
    // direction pair. The count wraps silently at its width; a follower must
    // work on differences, not on absolute values, across a long run.
    // The step pulse and the new count appear on the same edge.
    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            aux_pos     <= pacer_pkg::POS_RST;
            aux_step    <= 1'b0;
            aux_dir_ccw <= 1'b0;
        end
        else
        begin
            aux_step <= aux_mv;                                                  // R2
            if (aux_mv)
            begin
                aux_dir_ccw <= ~aux_up;                                          // R1
                aux_pos     <= aux_up ? aux_pos + 32'h00000001 : aux_pos - 32'h00000001; // R1
            end
        end
    end

    // Source selection register. The select is registered once so that the
    // output multiplexer never sees a half-changed choice; a switch of source
    // may produce one jump of the output pair, which downstream must tolerate.
    // The select should therefore only be changed while followers are idle.
    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            src_ff <= pacer_pkg::SRC_AUX;
        else
            src_ff <= src_motor ? pacer_pkg::SRC_MOTOR : pacer_pkg::SRC_AUX;   // R3
    end

    // Scale factor is clamped to the denominator so resolution can only drop.
    // Any factor up to the denominator is accepted. Keeping the output count
    // per revolution a whole number is left to whoever sets the factor, since
    // only it knows the motor resolution.
    always_comb
    begin
        eff_scale = (scale_factor > pacer_pkg::SCALE_DEN) ? pacer_pkg::SCALE_DEN : scale_factor; // R7
        acc_sum   = {1'b0, acc_ff} + eff_scale;                                 // R11
        acc_ovf   = acc_sum[12];                                                // R6
        acc_dif   = {1'b0, acc_ff} - eff_scale;
        acc_unf   = acc_dif[12];
    end

    // Scaling accumulator. Counting down undoes counting up exactly, so the
    // output position depends only on the motor position, not on the path.
    // With a factor that does not divide evenly the output drifts slowly against
    // the motor in one direction of travel; that drift is inherent, not lost counts.
    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            acc_ff       <= 12'h000;
            scl_state_ff <= 2'h0;
        end
        else if (mot_mv)
        begin
            if (mot_up)
            begin
                acc_ff <= acc_sum[11:0];                                        // R11
                if (acc_ovf)
                    scl_state_ff <= scl_state_ff + 2'h1;                        // R11
            end
            else
            begin
                acc_ff <= acc_dif[11:0];                                        // R9
                if (acc_unf)
                    scl_state_ff <= scl_state_ff - 2'h1;                        // R9
            end
        end
    end

    // Output pair. Gray walk 00,01,11,10 steps B before A for up counts.
    // Each branch is a single register load, so the pair changes on one edge
    // and a downstream decoder never sees a transient third state.
    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            quad_out <= pacer_pkg::QUAD_RST;
        else
        begin
            case (src_ff)
                pacer_pkg::SRC_AUX:
                    quad_out <= aux_s2_ff;                                      // R4 R8
                pacer_pkg::SRC_MOTOR:
                    if (scale_en)
                        quad_out <= {scl_state_ff[1], ^scl_state_ff};           // R5 R6
                    else
                        quad_out <= mot_s2_ff;                                  // R5
                default:
                    quad_out <= pacer_pkg::QUAD_RST;
            endcase
        end
    end

endmodule : pacer_quadrature_repeater

`default_nettype wire

// >>> tb/pacer_props.sv
// Concurrent checks on the ports of the pacer quadrature repeater.
`timescale 1ns/1ps
`default_nettype none
module pacer_props
(
    input wire logic                        clk,         // Clock.
    input wire logic                        arst_n,      // Reset, active low.
    input wire pacer_pkg::quad_t            aux_in,      // Auxiliary pair.
    input wire pacer_pkg::quad_t            motor_in,    // Motor pair.
    input wire logic                        src_motor,   // Source select.
    input wire logic                        scale_en,    // Scaling enable.
    input wire logic [pacer_pkg::POS_W-1:0] aux_pos,     // Decoded position.
    input wire logic                        aux_step,    // Count pulse.
    input wire logic                        aux_dir_ccw, // Count direction.
    input wire pacer_pkg::quad_t            quad_out     // Output pair.
);
    // Settling windows of six cycles (five for the Gray check) cover the synchroniser and output latency.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_step_one_cycle: assert property (aux_step |=> !aux_step) else $error("step pulse too long");
    chk_count_up: assert property (aux_step && !aux_dir_ccw |-> aux_pos == $past(aux_pos) + 32'h1)
        else $error("up count wrong");
    chk_count_down: assert property (aux_step && aux_dir_ccw |-> aux_pos == $past(aux_pos) - 32'h1)
        else $error("down count wrong");
    chk_pos_hold: assert property (!aux_step |-> $stable(aux_pos)) else $error("position moved without step");
    chk_aux_repeat: assert property ((!src_motor && $stable(aux_in)) [*6] |-> quad_out == aux_in)
        else $error("aux repeat differs");
    chk_motor_direct: assert property ((src_motor && !scale_en && $stable(motor_in)) [*6] |-> quad_out == motor_in)
        else $error("motor repeat differs");
    chk_scaled_gray: assert property ((src_motor && scale_en) [*5] ##0 $changed(quad_out)
        |-> $countones(quad_out ^ $past(quad_out)) == 1) else $error("scaled output skipped a state");
    chk_scaled_idle: assert property ((src_motor && scale_en && $stable(motor_in)) [*6] |-> $stable(quad_out))
        else $error("scaled output moved without motor count");
endmodule : pacer_props
`default_nettype wire

// >>> tb/quad_source.sv
// Behavioural quadrature encoder that stands at the auxiliary or motor pair.
`timescale 1ns/1ps
`default_nettype none
module quad_source
(
    input  wire logic       clk, // Clock for step timing.
    output pacer_pkg::quad_t q   // Encoder pair.
);
    logic [1:0] pos_ff = 2'h0;
    // Gray order 00,01,11,10 counts up; an increment of 2 flips both phases at once.
    assign q = '{a: pos_ff[1], b: pos_ff[1] ^ pos_ff[0]};
    // Steps are spaced nine cycles apart so every edge settles before the next.
    task step(input logic [1:0] inc);
        @(posedge clk);
        pos_ff <= pos_ff + inc;
        repeat (8) @(posedge clk);
    endtask : step
endmodule : quad_source
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking testbench of the pacer quadrature repeater.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, arst_n = 1'b0, idx = 1'b0, src = 1'b0, sen = 1'b1, stp, ccw, aidx;
    logic [12:0] fac = 13'h0800;
    logic [31:0] pos;
    pacer_pkg::quad_t aux, mot, qo, qprev = 2'h0, qsave;
    int fails = 0, checks = 0, nstep = 0, nchg = 0, cyc = 0;
    quad_source u_quad_source (.clk(clk), .q(aux));
    quad_source u_quad_source_m (.clk(clk), .q(mot));
    pacer_quadrature_repeater u_pacer_quadrature_repeater (.clk(clk), .arst_n(arst_n), .aux_in(aux),
        .aux_index_in(idx), .motor_in(mot), .src_motor(src), .scale_en(sen), .scale_factor(fac),
        .aux_pos(pos), .aux_step(stp), .aux_dir_ccw(ccw), .aux_index(aidx), .quad_out(qo));
    initial forever #50 clk = ~clk;
    // Count step pulses and output edges; a hang past the ceiling ends the run.
    always @(posedge clk)
    begin
        nstep += (stp === 1'b1);
        nchg += (qo !== qprev);
        qprev <= qo;
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            results();
        end
    end
    task check(string name, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check
    task results();
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // Five up, two down, then a double-phase jump that must not count; scaling stays on here.
    task aux_count();
        repeat (5) u_quad_source.step(2'h1);
        repeat (2) u_quad_source.step(2'h3);
        check("aux_pos", 32'h3, pos);
        check("aux_dir_ccw", 32'h1, 32'(ccw));
        check("quad_out", 32'(aux), 32'(qo));
        u_quad_source.step(2'h2);
        check("aux_pos", 32'h3, pos);
        check("aux_step", 32'h7, 32'(nstep));
        idx <= 1'b1;
        repeat (6) @(posedge clk);
        check("aux_index", 32'h1, 32'(aidx));
    endtask : aux_count
    // Direct motor repeat, then half scaling out and back to the start, then clamped scaling.
    task motor_paths();
        src <= 1'b1;
        sen <= 1'b0;
        repeat (3) u_quad_source_m.step(2'h1);
        check("quad_out", 32'(mot), 32'(qo));
        sen <= 1'b1;
        repeat (8) @(posedge clk);
        qsave = qo;
        nchg = 0;
        repeat (16) u_quad_source_m.step(2'h1);
        check("scaled edges", 32'h8, 32'(nchg));
        repeat (16) u_quad_source_m.step(2'h3);
        check("returned out", 32'(qsave), 32'(qo));
        fac <= 13'h1388;
        repeat (4) @(posedge clk);
        nchg = 0;
        repeat (8) u_quad_source_m.step(2'h1);
        check("clamped edges", 32'h8, 32'(nchg));
    endtask : motor_paths
    // Off-ratio factor out and back, then a reset in mid-run with both pairs away from 00.
    task restart_paths();
        fac <= 13'h0FFF;
        repeat (4) @(posedge clk);
        qsave = qo;
        repeat (6) u_quad_source_m.step(2'h1);
        repeat (6) u_quad_source_m.step(2'h3);
        check("off-ratio return", 32'(qsave), 32'(qo));
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        check("aux_pos in reset", 32'h0, pos);
        check("quad_out in reset", 32'h0, 32'(qo));
        arst_n <= 1'b1;
        src <= 1'b0;
        repeat (8) @(posedge clk);
        check("aux_pos after reset", 32'h0, pos);
        check("quad_out after reset", 32'(aux), 32'(qo));
        check("aux_index after reset", 32'h1, 32'(aidx));
        idx <= 1'b0;
        u_quad_source.step(2'h1);
        check("aux_pos after step", 32'h1, pos);
        check("aux_dir_ccw", 32'h0, 32'(ccw));
        check("aux_index", 32'h0, 32'(aidx));
    endtask : restart_paths
    initial
    begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        aux_count();
        motor_paths();
        restart_paths();
        results();
    end
endmodule : testbench
bind pacer_quadrature_repeater pacer_props u_pacer_props (.clk(clk), .arst_n(arst_n), .aux_in(aux_in),
    .motor_in(motor_in), .src_motor(src_motor), .scale_en(scale_en), .aux_pos(aux_pos), .aux_step(aux_step),
    .aux_dir_ccw(aux_dir_ccw), .quad_out(quad_out));
`default_nettype wire
